// [rtl/adf_filter_top.sv]
// Digital back end of the delta-sigma converter: two-stage sinc decimator, FIR-mode
// path, PGA/reference alarm flags, configuration registers and result FIFO.
// Assumes a parallel register port driven by the serial-interface logic on mclk_in,
// and raw comparator and modulator levels arriving asynchronously.
`timescale 1ns/1ps
`include "adf_consts.svh"
module adf_filter_top import adf_pkg::*; #(
    parameter int FIFO_DEPTH = 4
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Analog front end (asynchronous levels)
    input wire logic mod_bit_in,
    input wire logic [7:0] pga_alarm_in,
    input wire logic ref_low_in,
    // Analog controls
    output logic [3:0] pga_gain_code_out,
    output logic pga_atten_mode_out,
    output logic [2:0] input_mux_out,
    output logic [3:0] reference_select_out,
    // Register port
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    input wire logic register_check_error_in,
    output logic [7:0] primary_status_out,
    // Conversion results
    output logic sample_strobe_out,
    output logic [23:0] sample_data_out,
    output logic result_valid_out,
    output logic [23:0] result_data_out,
    input wire logic result_ready_in
);
    logic [2:0] div_q;
    logic mod_en;
    logic mod_s1_q, mod_s2_q;
    logic [7:0] alm_s1_q, alm_s2_q;
    logic ref_s1_q, ref_s2_q;
    logic [7:0] filt_q, gain_q, pga_q;
    logic [3:0] ref_q;
    logic crc_q, ovr_q, low_reference_alarm_q, summary;
    logic wr_filt, rd_pga, rd_aux;
    logic [4:0] rate;
    adf_filter_t ftype;
    logic fir_mode, s1_direct;
    logic [2:0] ord2;
    logic [6:0] s1_decim, s1_shift, s2_shift;
    logic [12:0] d2, s2_decim;
    logic [3:0] c2;
    logic [1:0] avg_l;
    logic s1_valid, s2_valid;
    logic signed [31:0] s1_dout;
    logic signed [75:0] s2_dout;
    logic [23:0] s1_sat, s2_sat;
    logic signed [26:0] avg_sum_q, avg_next;
    logic [2:0] avg_cnt_q;
    logic avg_done;
    logic res_new;
    logic [23:0] res_val;
    logic pend_q;
    logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [23:0] fifo_out_data;
    logic [7:0] prim_d;

    function automatic logic [23:0] adf_sat(input logic signed [75:0] v);
        if (v > 76'sh7FFFFF) begin
            return 24'h7FFFFF;
        end else if (v < -76'sh800000) begin
            return 24'h800000;
        end
        return v[23:0];
    endfunction

    // Modulator bit rate and the bit synchroniser
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_q <= 3'h0;
            mod_s1_q <= 1'b0;
            mod_s2_q <= 1'b0;
        end else begin
            div_q <= div_q + 3'h1;
            mod_s1_q <= mod_bit_in;
            mod_s2_q <= mod_s1_q;
        end
    end
    assign mod_en = div_q == 3'(`ADF_MOD_DIV - 1);

    // Comparator synchronisers; an excursion shorter than a clock period may be missed
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            alm_s1_q <= 8'h00;
            alm_s2_q <= 8'h00;
            ref_s1_q <= 1'b0;
            ref_s2_q <= 1'b0;
        end else begin
            alm_s1_q <= pga_alarm_in;
            alm_s2_q <= alm_s1_q;
            ref_s1_q <= ref_low_in;
            ref_s2_q <= ref_s1_q;
        end
    end

    // Configuration registers
    assign wr_filt = reg_wr_in && (reg_addr_in == `ADF_ADDR_FILTER);
    assign rd_pga = reg_rd_in && (reg_addr_in == `ADF_ADDR_PGA);
    assign rd_aux = reg_rd_in && (reg_addr_in == `ADF_ADDR_AUX);
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            filt_q <= `ADF_FILTER_RST;
        end else if (wr_filt) begin
            filt_q <= reg_wdata_in;
        end
    end
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gain_q <= `ADF_GAIN_RST;
        end else if (reg_wr_in && (reg_addr_in == `ADF_ADDR_GAIN)) begin
            gain_q <= reg_wdata_in;
        end
    end
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ref_q <= `ADF_REF_RST;
        end else if (reg_wr_in && (reg_addr_in == `ADF_ADDR_REF)) begin
            ref_q <= reg_wdata_in[3:0];
        end
    end

    // Analog control outputs; reserved gain codes fall back to the highest gain
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pga_gain_code_out <= 4'h0;
            pga_atten_mode_out <= 1'b1;
            input_mux_out <= 3'h5;
            reference_select_out <= `ADF_REF_RST;
        end else begin
            if (gain_q[3:0] > `ADF_GAIN_MAX) begin
                pga_gain_code_out <= `ADF_GAIN_MAX;
            end else begin
                pga_gain_code_out <= gain_q[3:0];
            end
            pga_atten_mode_out <= gain_q[3:0] < `ADF_ATTEN_LIMIT;
            input_mux_out <= gain_q[6:4];
            reference_select_out <= ref_q;
        end
    end

    // Alarm flags: the set term is ORed after the clear so a coincident event survives
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pga_q <= 8'h00;
        end else begin
            pga_q <= (pga_q & ~{8{rd_pga}}) | alm_s2_q;
        end
    end
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            crc_q <= 1'b0;
            ovr_q <= 1'b0;
        end else begin
            crc_q <= (crc_q && !rd_aux) || register_check_error_in;
            ovr_q <= (ovr_q && !rd_aux) || (res_new && pend_q && !fifo_in_ready);
        end
    end
    // Reference alarm ignores reads and waits for a finished conversion
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            low_reference_alarm_q <= 1'b0;
        end else if (ref_s2_q) begin
            low_reference_alarm_q <= 1'b1;
        end else if (res_new) begin
            low_reference_alarm_q <= 1'b0;
        end
    end
    assign summary = (|pga_q) || crc_q;
    always_comb begin
        prim_d = 8'h00;
        prim_d[`ADF_BIT_SUMMARY] = summary;
        prim_d[`ADF_BIT_LOW_REFERENCE_ALARM] = low_reference_alarm_q;
    end
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            primary_status_out <= 8'h00;
        end else begin
            primary_status_out <= prim_d;
        end
    end

    // Read port, one cycle after the strobe
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            if (reg_addr_in == `ADF_ADDR_PRIMARY) begin
                reg_rdata_out <= prim_d;
            end else if (reg_addr_in == `ADF_ADDR_FILTER) begin
                reg_rdata_out <= filt_q;
            end else if (reg_addr_in == `ADF_ADDR_REF) begin
                reg_rdata_out <= {4'h0, ref_q};
            end else if (reg_addr_in == `ADF_ADDR_GAIN) begin
                reg_rdata_out <= gain_q;
            end else if (reg_addr_in == `ADF_ADDR_PGA) begin
                reg_rdata_out <= pga_q;
            end else if (reg_addr_in == `ADF_ADDR_AUX) begin
                reg_rdata_out <= {6'h00, ovr_q, crc_q};
            end else begin
                reg_rdata_out <= 8'h00;
            end
        end
    end

    // Rate and mode decode
    assign rate = (filt_q[4:0] > `ADF_RATE_MAX) ? `ADF_RATE_MAX : filt_q[4:0];
    always_comb begin
        case (filt_q[7:5])
            3'h0: ftype = ADF_SINC1;
            3'h1: ftype = ADF_SINC3;
            3'h2: ftype = ADF_SINC4;
            3'h3: ftype = ADF_FIR;
            default: ftype = ADF_SINC4;
        endcase
    end
    // FIR requested at a rate it cannot serve runs as sinc4
    assign fir_mode = (ftype == ADF_FIR) && (rate <= `ADF_RATE_FIR_MAX)
        && (rate != `ADF_RATE_NO_FIR);
    assign s1_direct = rate >= `ADF_RATE_FIRST_S1;
    assign ord2 = (ftype == ADF_SINC1) ? 3'h1 : (ftype == ADF_SINC3) ? 3'h3 : 3'h4;
    always_comb begin
        d2 = 13'h0002;
        c2 = 4'h1;
        s1_decim = `ADF_S1_LOW_DECIM;
        s1_shift = 7'h07;
        avg_l = 2'h0;
        case (rate)
            5'h00: begin d2 = 13'h1680; c2 = 4'hD; avg_l = 2'h3; end
            5'h01: begin d2 = 13'h0B40; c2 = 4'hC; avg_l = 2'h2; end
            5'h02: begin d2 = 13'h05A0; c2 = 4'hB; avg_l = 2'h1; end
            5'h03: begin d2 = 13'h0363; c2 = 4'hA; end
            5'h04: begin d2 = 13'h02D0; c2 = 4'hA; end
            5'h05: begin d2 = 13'h0120; c2 = 4'h9; end
            5'h06: begin d2 = 13'h00F0; c2 = 4'h8; end
            5'h07: begin d2 = 13'h0090; c2 = 4'h8; end
            5'h08: begin d2 = 13'h0024; c2 = 4'h6; end
            5'h09: begin d2 = 13'h000C; c2 = 4'h4; end
            5'h0A: begin d2 = 13'h0006; c2 = 4'h3; end
            5'h0B: begin d2 = 13'h0003; c2 = 4'h2; end
            5'h0E: begin s1_decim = 7'h30; s1_shift = 7'h05; end
            5'h0F: begin s1_decim = 7'h24; s1_shift = 7'h03; end
            5'h10: begin s1_decim = 7'h20; s1_shift = 7'h02; end
            default: begin d2 = 13'h0002; c2 = 4'h1; end
        endcase
    end
    assign s2_decim = fir_mode ? `ADF_FIR_DECIM : d2;
    // FIR path always decimates by 720, so its shift ignores the rate's own growth
    assign s2_shift = fir_mode ? 7'(`ADF_FIR_ORDER * 4'hA) : 7'(ord2 * c2);

    // First stage: sinc5 on the +1/-1 bit stream
    // A full-scale +1 stream at decimation 64 reaches 2^30, which needs 32 signed bits
    adf_sinc_stage #(.IW(2), .W(32), .MAXO(5), .DW(7)) u_stage1 (
        .clk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .clr_in(wr_filt),
        .order_in(`ADF_S1_ORDER),
        .decim_in(s1_decim),
        .shift_in(s1_shift),
        .en_in(mod_en),
        .din_in(mod_s2_q ? 2'sh1 : 2'sh3),
        .dout_out(s1_dout),
        .valid_out(s1_valid)
    );
    assign s1_sat = adf_sat(76'(s1_dout));

    // Second stage only ever sees the 14.4 kSPS first-stage stream
    adf_sinc_stage #(.IW(24), .W(76), .MAXO(4), .DW(13)) u_stage2 (
        .clk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .clr_in(wr_filt),
        .order_in(fir_mode ? `ADF_FIR_ORDER : ord2),
        .decim_in(s2_decim),
        .shift_in(s2_shift),
        .en_in(s1_valid && !s1_direct),
        .din_in($signed(s1_sat)),
        .dout_out(s2_dout),
        .valid_out(s2_valid)
    );
    assign s2_sat = adf_sat(s2_dout);

    // FIR-mode averager turning 20 SPS into 10, 5 and 2.5 SPS
    assign avg_next = avg_sum_q + 27'($signed(s2_sat));
    assign avg_done = fir_mode && s2_valid && (avg_cnt_q == 3'((1 << avg_l) - 1));
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            avg_sum_q <= '0;
            avg_cnt_q <= 3'h0;
        end else if (wr_filt || avg_done) begin
            avg_sum_q <= '0;
            avg_cnt_q <= 3'h0;
        end else if (fir_mode && s2_valid) begin
            avg_sum_q <= avg_next;
            avg_cnt_q <= avg_cnt_q + 3'h1;
        end
    end

    // Result selection by mode
    always_comb begin
        res_new = 1'b0;
        res_val = s2_sat;
        if (s1_direct) begin
            res_new = s1_valid;
            res_val = s1_sat;
        end else if (fir_mode) begin
            res_new = avg_done;
            res_val = 24'(avg_next >>> avg_l);
        end else begin
            res_new = s2_valid;
        end
    end
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sample_strobe_out <= 1'b0;
            sample_data_out <= 24'h000000;
        end else begin
            sample_strobe_out <= res_new;
            if (res_new) begin
                sample_data_out <= res_val;
            end
        end
    end

    // The filter cannot stall, so while the FIFO is full the pending word is overwritten by the newest and overrun is flagged
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_q <= 1'b0;
        end else if (sample_strobe_out) begin
            pend_q <= 1'b1;
        end else if (fifo_in_ready) begin
            pend_q <= 1'b0;
        end
    end
    adf_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(pend_q),
        .in_data_in(sample_data_out),
        .in_ready_out(fifo_in_ready),
        .out_valid_out(fifo_out_valid),
        .out_data_out(fifo_out_data),
        .out_ready_in(fifo_out_ready)
    );
    assign fifo_out_ready = !result_valid_out || result_ready_in;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            result_valid_out <= 1'b0;
            result_data_out <= 24'h000000;
        end else if (fifo_out_ready) begin
            result_valid_out <= fifo_out_valid;
            result_data_out <= fifo_out_data;
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    sequence seq_mod_gap;
        !mod_en [*7] ##1 mod_en;
    endsequence
    sequence seq_alarm_seen;
        alm_s2_q != 8'h00;
    endsequence
    chk_mod_period: assert property (mod_en |=> seq_mod_gap)
        else $error("modulator enable not every eight clocks");
    chk_direct_out: assert property (s1_valid && s1_direct |=> sample_strobe_out)
        else $error("fast rate result not taken from the first stage");
    chk_fir_rates: assert property (fir_mode |-> rate <= 5'h04 && rate != 5'h03)
        else $error("FIR path active at an unsupported rate");
    chk_alarm_latch: assert property (seq_alarm_seen |=>
        (pga_q & $past(alm_s2_q)) == $past(alm_s2_q))
        else $error("alarm event lost");
    chk_alarm_hold: assert property (!rd_pga |=> (pga_q & $past(pga_q)) == $past(pga_q))
        else $error("alarm flag cleared without a read");
    chk_summary_set: assert property (seq_alarm_seen |-> ##2 primary_status_out[4])
        else $error("summary flag missing after alarm");
    chk_summary_fall: assert property ($fell(primary_status_out[4]) |->
        $past(pga_q) == 8'h00 && !$past(crc_q))
        else $error("summary cleared while a source stays set");
    chk_low_reference_alarm_set: assert property (ref_s2_q |-> ##2 primary_status_out[3])
        else $error("low reference not reported");
    chk_low_reference_alarm_hold: assert property (low_reference_alarm_q && !res_new |=> low_reference_alarm_q)
        else $error("reference alarm cleared without a conversion");
    chk_strobe_once: assert property (sample_strobe_out |=> !sample_strobe_out)
        else $error("result strobe longer than one cycle");
    chk_atten: assert property (pga_atten_mode_out == (pga_gain_code_out < 4'h4))
        else $error("attenuation mode does not match gain code");
endmodule

// [include/adf_consts.svh]
// Offsets, field positions, reset values and timing counts of the filter back end.
// Included by every design file that decodes registers or rate codes.
`ifndef ADF_CONSTS_SVH
`define ADF_CONSTS_SVH
`define ADF_MOD_DIV 8
`define ADF_ADDR_PRIMARY 8'h01
`define ADF_ADDR_FILTER 8'h03
`define ADF_ADDR_REF 8'h06
`define ADF_ADDR_GAIN 8'h10
`define ADF_ADDR_PGA 8'h11
`define ADF_ADDR_AUX 8'h12
`define ADF_FILTER_RST 8'h04
`define ADF_GAIN_RST 8'h50
`define ADF_REF_RST 4'h0
`define ADF_BIT_SUMMARY 4
`define ADF_BIT_LOW_REFERENCE_ALARM 3
`define ADF_RATE_FIRST_S1 5'h0D
`define ADF_RATE_MAX 5'h10
`define ADF_RATE_FIR_MAX 5'h04
`define ADF_RATE_NO_FIR 5'h03
`define ADF_FIR_DECIM 13'h2D0
`define ADF_FIR_ORDER 3'h4
`define ADF_S1_ORDER 3'h5
`define ADF_S1_LOW_DECIM 7'h40
`define ADF_ATTEN_LIMIT 4'h4
`define ADF_GAIN_MAX 4'hB
`endif

// [include/adf_pkg.sv]
// Types shared by the filter back end.
// Needs nothing else.
package adf_pkg;
    typedef enum logic [1:0] {ADF_SINC1, ADF_SINC3, ADF_SINC4, ADF_FIR} adf_filter_t;
    typedef logic [23:0] adf_result_t;
endpackage

// [rtl/adf_sinc_stage.sv]
// Variable-order, variable-decimation sinc (CIC) stage.
// Assumes en_in marks each input sample and clr_in flushes on reconfiguration.
`timescale 1ns/1ps
module adf_sinc_stage import adf_pkg::*; #(
    parameter int IW = 2,
    parameter int W = 31,
    parameter int MAXO = 5,
    parameter int DW = 7
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Control
    input wire logic clr_in,
    input wire logic [2:0] order_in,
    input wire logic [DW-1:0] decim_in,
    input wire logic [6:0] shift_in,
    // Samples
    input wire logic en_in,
    input wire logic signed [IW-1:0] din_in,
    output logic signed [W-1:0] dout_out,
    output logic valid_out
);
    if (IW >= W || MAXO < 1 || MAXO > 7) begin : g_bad
        $error("adf_sinc_stage: unusable width or order");
    end
    logic signed [W-1:0] ii [0:MAXO];
    logic signed [W-1:0] cc [0:MAXO];
    logic signed [W-1:0] acc_q [0:MAXO-1];
    logic signed [W-1:0] dly_q [0:MAXO-1];
    logic [DW-1:0] cnt_q;
    logic take;
    assign ii[0] = W'(din_in);
    assign cc[0] = ii[MAXO];
    assign take = en_in && (cnt_q == decim_in - DW'(1));
    // Stages above the selected order pass straight through
    for (genvar g = 0; g < MAXO; g++) begin : g_stage
        always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                acc_q[g] <= '0;
                dly_q[g] <= '0;
            end else if (clr_in) begin
                acc_q[g] <= '0;
                dly_q[g] <= '0;
            end else begin
                if (en_in) begin
                    acc_q[g] <= acc_q[g] + ii[g];
                end
                if (take) begin
                    dly_q[g] <= cc[g];
                end
            end
        end
        assign ii[g+1] = (3'(g) < order_in) ? acc_q[g] : ii[g];
        assign cc[g+1] = (3'(g) < order_in) ? cc[g] - dly_q[g] : cc[g];
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
        end else if (clr_in || take) begin
            cnt_q <= '0;
        end else if (en_in) begin
            cnt_q <= cnt_q + DW'(1);
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dout_out <= '0;
            valid_out <= 1'b0;
        end else begin
            valid_out <= take && !clr_in;
            if (take) begin
                dout_out <= cc[MAXO] >>> shift_in;
            end
        end
    end
    chk_valid_cause: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        valid_out |-> $past(en_in) && ($past(cnt_q) == $past(decim_in) - DW'(1)))
        else $error("sinc stage output without a completed decimation period");
endmodule

// [rtl/adf_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth must be a power of two.
`timescale 1ns/1ps
module adf_fifo import adf_pkg::*; #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
        $error("adf_fifo: depth must be a power of two, at least 2");
    end
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;
    assign in_ready_out = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid_out = wr_q != rd_q;
    assign out_data_out = mem[rd_q[AW-1:0]];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data_in;
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + (AW+1)'(1);
            end
            if (pop) begin
                rd_q <= rd_q + (AW+1)'(1);
            end
        end
    end
    chk_fifo_bound: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (wr_q - rd_q) <= (AW+1)'(DEPTH))
        else $error("fifo holds more words than its depth");
endmodule

// [tb/adf_host_model.sv]
// Host controller model on the parallel register port.
// One transfer at a time, changed on the falling edge.
`timescale 1ns/1ps
module adf_host_model (
    // Clock
    input wire logic clk_in,
    // Register port
    input wire logic [7:0] rdata_in,
    output logic wr_out = 0,
    output logic rd_out = 0,
    output logic [7:0] addr_out = 0,
    output logic [7:0] wdata_out = 0
);
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_in);
        {wr_out, addr_out, wdata_out} = {1'b1, a, v};
        @(negedge clk_in);
        // Idle bus shows inverted values, not stale ones
        {wr_out, addr_out, wdata_out} = {1'b0, ~a, ~v};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk_in);
        {rd_out, addr_out} = {1'b1, a};
        @(negedge clk_in);
        {rd_out, addr_out} = {1'b0, ~a};
        v = rdata_in;
    endtask
    task automatic service(input logic s, output logic [7:0] p, output logic [7:0] x);
        p = 0;
        x = 0;
        if (s) begin
            rd(8'h11, p);
            rd(8'h12, x);
        end
    endtask
endmodule

// [tb/adf_filter_top_tb.sv]
// Self-checking bench for the filter back end.
// Inputs change on the falling edge; the host model owns the register port.
`timescale 1ns/1ps
module adf_filter_top_tb import adf_pkg::*;;
    logic mclk_in = 0, rst_n_in = 0, mod_bit_in = 0, ref_low_in = 0;
    logic register_check_error_in = 0, result_ready_in = 0;
    logic [7:0] pga_alarm_in = 0;
    logic reg_wr_in, reg_rd_in, pga_atten_mode_out, sample_strobe_out, result_valid_out;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, primary_status_out, d, x;
    logic [3:0] pga_gain_code_out, reference_select_out;
    logic [2:0] input_mux_out;
    logic [23:0] sample_data_out, result_data_out;
    int n_mismatch = 0, samples_checked = 0, cyc = 0, t;
    // Gain code written, code expected, attenuation expected
    logic [8:0] rows [5] = '{9'h001, 9'h067, 9'h088, 9'h176, 9'h196};
    adf_filter_top uut (.mclk_in, .rst_n_in, .mod_bit_in, .pga_alarm_in, .ref_low_in,
        .pga_gain_code_out, .pga_atten_mode_out, .input_mux_out, .reference_select_out,
        .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
        .register_check_error_in, .primary_status_out, .sample_strobe_out,
        .sample_data_out, .result_valid_out, .result_data_out, .result_ready_in);
    adf_host_model host (.clk_in(mclk_in), .rdata_in(reg_rdata_out), .wr_out(reg_wr_in),
        .rd_out(reg_rd_in), .addr_out(reg_addr_in), .wdata_out(reg_wdata_in));
    always #12.5 mclk_in = ~mclk_in;
    always @(negedge mclk_in) mod_bit_in <= ~mod_bit_in;
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wait_strobe;
        for (int k = 0; k < 600 && sample_strobe_out !== 1'b1; k++) @(negedge mclk_in);
        @(negedge mclk_in);
    endtask
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 10000) begin
            n_mismatch++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (20) @(negedge mclk_in);
        rst_n_in = 1;
        chk(reference_select_out, 0);
        chk(pga_atten_mode_out, 1);
        chk(input_mux_out, 5);
        host.rd(8'h7F, d);
        chk(d, 0);
        foreach (rows[i]) begin
            host.wr(8'h10, {4'h5, rows[i][8:5]});
            @(negedge mclk_in);
            chk(pga_gain_code_out, rows[i][4:1]);
            chk(pga_atten_mode_out, rows[i][0]);
        end
        $display("reset and gain done");
        pga_alarm_in = 8'h24;
        repeat (3) @(negedge mclk_in);
        pga_alarm_in = 0;
        repeat (6) @(negedge mclk_in);
        chk(primary_status_out[4], 1);
        host.service(primary_status_out[4], d, x);
        chk(d, 8'h24);
        repeat (3) @(negedge mclk_in);
        chk(primary_status_out[4], 0);
        register_check_error_in = 1;
        @(negedge mclk_in);
        register_check_error_in = 0;
        repeat (3) @(negedge mclk_in);
        chk(primary_status_out[4], 1);
        host.rd(8'h12, d);
        chk(d[0], 1);
        repeat (3) @(negedge mclk_in);
        chk(primary_status_out[4], 0);
        // Alarm still present while the clearing read lands
        pga_alarm_in = 8'h01;
        repeat (6) @(negedge mclk_in);
        host.rd(8'h11, d);
        pga_alarm_in = 0;
        host.rd(8'h11, d);
        chk(d, 8'h01);
        host.rd(8'h11, d);
        chk(d, 8'h01);
        host.rd(8'h11, d);
        chk(d, 0);
        $display("alarm flags done");
        host.wr(8'h03, 8'h10);
        ref_low_in = 1;
        repeat (6) @(negedge mclk_in);
        host.rd(8'h01, d);
        chk(d[3], 1);
        repeat (3) @(negedge mclk_in);
        chk(primary_status_out[3], 1);
        ref_low_in = 0;
        host.rd(8'h01, d);
        chk(d[3], 1);
        wait_strobe();
        t = cyc;
        wait_strobe();
        chk(cyc - t, 256);
        chk(primary_status_out[3], 0);
        repeat (5) wait_strobe();
        chk(sample_data_out, 24'h7FFFFF);
        chk(result_valid_out, 1);
        host.rd(8'h12, d);
        chk(d[1], 1);
        wait_strobe();
        result_ready_in = 1;
        repeat (12) @(negedge mclk_in);
        chk(result_valid_out, 0);
        $display("rate and buffer done");
        tally_and_finish;
    end
endmodule
